/* inc/spt_pkg.sv */
// Shared constants and types for the stepper phase translator and chopper
package spt_pkg;

    // Clock period of clk_in in nanoseconds
    localparam int unsigned SPT_CLK_PERIOD_NS = 8;

    // Translator state encoding: index 0 is state 1 (home)
    localparam int unsigned SPT_STATE_W    = 3;
    localparam logic [2:0]  SPT_HOME_STATE = 3'h0;
    localparam logic [2:0]  SPT_HALF_INC   = 3'h1;
    localparam logic [2:0]  SPT_FULL_INC   = 3'h2;
    localparam logic [3:0]  SPT_PHASE_HOME = 4'h5;

    // Phase patterns PHASE_OUTPUTS for states 1..8, half-step order
    localparam logic [3:0]  SPT_PH_S1 = 4'h5;
    localparam logic [3:0]  SPT_PH_S2 = 4'h1;
    localparam logic [3:0]  SPT_PH_S3 = 4'h9;
    localparam logic [3:0]  SPT_PH_S4 = 4'h8;
    localparam logic [3:0]  SPT_PH_S5 = 4'hA;
    localparam logic [3:0]  SPT_PH_S6 = 4'h2;
    localparam logic [3:0]  SPT_PH_S7 = 4'h6;
    localparam logic [3:0]  SPT_PH_S8 = 4'h4;

    // Pair field positions inside the PHASE_OUTPUTS nibble
    localparam int unsigned SPT_AB_HI = 3;
    localparam int unsigned SPT_AB_LO = 2;
    localparam int unsigned SPT_CD_HI = 1;
    localparam int unsigned SPT_CD_LO = 0;
    localparam logic [1:0]  SPT_PAIR_OFF  = 2'h0;
    localparam logic [1:0]  SPT_PAIR_BOTH = 2'h3;

    // Chopper oscillator: period is about 0.69 RC
    localparam int unsigned SPT_OSC_RC_NS      = 20000;
    localparam int unsigned SPT_OSC_PERIOD_NS  = (SPT_OSC_RC_NS * 69) / 100;
    localparam int unsigned SPT_OSC_PERIOD_CYC = SPT_OSC_PERIOD_NS / SPT_CLK_PERIOD_NS;

    // Step doubler: ghost pulse delayed by 0.75 RC
    localparam int unsigned SPT_DBL_RC_NS      = 100000;
    localparam int unsigned SPT_DBL_DELAY_NS   = (SPT_DBL_RC_NS * 75) / 100;
    localparam int unsigned SPT_DBL_DELAY_CYC  = SPT_DBL_DELAY_NS / SPT_CLK_PERIOD_NS;

    // Counter width for oscillator and doubler timers
    localparam int unsigned SPT_CNT_W  = 20;
    localparam logic [19:0] SPT_CNT_ONE  = 20'h00001;
    localparam logic [19:0] SPT_CNT_ZERO = 20'h00000;

    // Synchroniser input bit positions
    localparam int unsigned SPT_SYNC_W     = 11;
    localparam int unsigned SPT_IX_STEP    = 0;
    localparam int unsigned SPT_IX_DIR     = 1;
    localparam int unsigned SPT_IX_HALF    = 2;
    localparam int unsigned SPT_IX_RESET_N = 3;
    localparam int unsigned SPT_IX_ENABLE  = 4;
    localparam int unsigned SPT_IX_CTRL    = 5;
    localparam int unsigned SPT_IX_SENS_AB = 6;
    localparam int unsigned SPT_IX_SENS_CD = 7;
    localparam int unsigned SPT_IX_EXTSYNC = 8;
    localparam int unsigned SPT_IX_OSC_GND = 9;
    localparam int unsigned SPT_IX_DBL_GND = 10;

    // Sequencing modes
    typedef enum logic [1:0] {
        SPT_MODE_HALF,
        SPT_MODE_NORMAL,
        SPT_MODE_WAVE
    } spt_mode_t;

    // Doubler states
    typedef enum logic [0:0] {
        SPT_DBL_IDLE,
        SPT_DBL_WAIT
    } spt_dbl_state_t;

endpackage : spt_pkg

/* core/spt_sync2.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module spt_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : spt_sync2

/* core/spt_translator_chopper.sv */
// Stepper phase translator with dual PWM current chopper and step doubler
`timescale 1ns/1ps
module spt_translator_chopper #(
    parameter int unsigned OSC_PERIOD_CYC = spt_pkg::SPT_OSC_PERIOD_CYC,
    parameter int unsigned DBL_DELAY_CYC  = spt_pkg::SPT_DBL_DELAY_CYC
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Controller inputs (pins, asynchronous)
    input  wire logic       step_clk_n_in,
    input  wire logic       rotation_dir_in,
    input  wire logic       half_full_in,
    input  wire logic       translator_reset_n_in,
    input  wire logic       enable_in,
    input  wire logic       chopper_target_in,
    // Current comparator results (high when current reached reference)
    input  wire logic       current_sense_ab_in,
    input  wire logic       current_sense_cd_in,
    // Chopper oscillator synchronisation
    input  wire logic       ext_sync_in,
    input  wire logic       chopper_osc_pin_grounded_in,
    // Doubler control (high when doubler pin is grounded)
    input  wire logic       doubler_grounded_in,
    // Power stage drive
    output logic [3:0]      phase_outputs_out,
    output logic            pair_ab_inhibit_n_out,
    output logic            pair_cd_inhibit_n_out,
    // Status
    output logic            home_out,
    output logic            dir_mem_out,
    output logic            sync_out
);

    logic [spt_pkg::SPT_SYNC_W-1:0]  pins_sync;
    logic                            step_sync;
    logic                            step_prev;
    logic                            step_edge;
    logic                            ext_sync_prev;
    logic                            osc_pulse;
    logic                            int_osc_pulse;
    logic [spt_pkg::SPT_CNT_W-1:0]   osc_cnt;
    logic [spt_pkg::SPT_CNT_W-1:0]   dbl_cnt;
    spt_pkg::spt_dbl_state_t         dbl_state;
    logic                            ghost_step;
    logic                            dir_ff;
    logic [spt_pkg::SPT_STATE_W-1:0] state;
    logic [spt_pkg::SPT_STATE_W-1:0] step_inc;
    spt_pkg::spt_mode_t              mode;
    logic                            chopper_latch_ab;
    logic                            chopper_latch_cd;
    logic [3:0]                      phase_pattern;
    logic [3:0]                      next_phase;
    logic                            next_inh_ab;
    logic                            next_inh_cd;
    logic [1:0]                      pair_ab;
    logic [1:0]                      pair_cd;
    logic                            do_step;
    logic [1:0]                      sync_fill;

    // Reload values of the timing parameters, at counter width
    localparam logic [spt_pkg::SPT_CNT_W-1:0] OSC_RELOAD =
        spt_pkg::SPT_CNT_W'(OSC_PERIOD_CYC - 1);
    // Doubler reloads one short: the ghost moves the translator exactly the delay after the real step
    localparam logic [spt_pkg::SPT_CNT_W-1:0] DBL_RELOAD =
        spt_pkg::SPT_CNT_W'(DBL_DELAY_CYC - 1);

    // Pin inputs pass two flip-flops before use
    spt_sync2 #(
        .WIDTH (spt_pkg::SPT_SYNC_W)
    ) u_pin_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .async_in  ({doubler_grounded_in,
                     chopper_osc_pin_grounded_in,
                     ext_sync_in,
                     current_sense_cd_in,
                     current_sense_ab_in,
                     chopper_target_in,
                     enable_in,
                     translator_reset_n_in,
                     half_full_in,
                     rotation_dir_in,
                     step_clk_n_in}),
        .sync_out  (pins_sync)
    );

    // Phase decode of a translator state, starting from state 1
    function automatic logic [3:0] spt_decode(input logic [2:0] s);
        logic [3:0] p;
        p = spt_pkg::SPT_PH_S1;
        case (s)
            3'h0: p = spt_pkg::SPT_PH_S1;
            3'h1: p = spt_pkg::SPT_PH_S2;
            3'h2: p = spt_pkg::SPT_PH_S3;
            3'h3: p = spt_pkg::SPT_PH_S4;
            3'h4: p = spt_pkg::SPT_PH_S5;
            3'h5: p = spt_pkg::SPT_PH_S6;
            3'h6: p = spt_pkg::SPT_PH_S7;
            3'h7: p = spt_pkg::SPT_PH_S8;
            default: p = spt_pkg::SPT_PH_S1;
        endcase
        return p;
    endfunction : spt_decode

    // Synchroniser outputs carry their reset zeros for two edges; mark when they are real
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_fill <= 2'h0;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // Step strobe edge history, held at the idle high level until the synchroniser has flushed,
    // so its reset zero is not taken for a step once reset is released
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            step_prev <= 1'b1;
        end else begin
            step_prev <= sync_fill[1] ? step_sync : 1'b1;
        end
    end

    // Step taken on the low-to-high transition of the strobe
    assign step_sync = pins_sync[spt_pkg::SPT_IX_STEP];
    assign step_edge = step_sync & ~step_prev;

    // Doubler: one ghost step a fixed delay after a real step, unless another real step comes first
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dbl_state  <= spt_pkg::SPT_DBL_IDLE;
            dbl_cnt    <= spt_pkg::SPT_CNT_ZERO;
            ghost_step <= 1'b0;
        end else begin
            ghost_step <= 1'b0;
            case (dbl_state)
                spt_pkg::SPT_DBL_IDLE: begin
                    if (step_edge && !pins_sync[spt_pkg::SPT_IX_DBL_GND]) begin
                        dbl_cnt   <= DBL_RELOAD;
                        dbl_state <= spt_pkg::SPT_DBL_WAIT;
                    end
                end
                spt_pkg::SPT_DBL_WAIT: begin
                    if (pins_sync[spt_pkg::SPT_IX_DBL_GND]) begin
                        dbl_state <= spt_pkg::SPT_DBL_IDLE;
                    end else if (step_edge) begin
                        dbl_cnt <= DBL_RELOAD;  // New step restarts the delay
                    end else if (dbl_cnt <= spt_pkg::SPT_CNT_ONE) begin
                        ghost_step <= 1'b1;
                        dbl_state  <= spt_pkg::SPT_DBL_IDLE;
                    end else begin
                        dbl_cnt <= dbl_cnt - spt_pkg::SPT_CNT_ONE;
                    end
                end
                default: begin
                    dbl_state <= spt_pkg::SPT_DBL_IDLE;
                end
            endcase
        end
    end

    // Real and ghost steps both move the translator
    assign do_step = step_edge | ghost_step;

    // Direction flip-flop, sampled from the synchronised input;
    // keeps its reset value until the synchroniser holds a real level, so direction memory does not glitch
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_ff <= 1'b1;
        end else if (sync_fill[1]) begin
            dir_ff <= pins_sync[spt_pkg::SPT_IX_DIR];
        end
    end

    // Sequencing mode from step size and current state parity
    always_comb begin
        if (pins_sync[spt_pkg::SPT_IX_HALF]) begin
            mode     = spt_pkg::SPT_MODE_HALF;
            step_inc = spt_pkg::SPT_HALF_INC;
        end else if (state[0] == 1'b0) begin
            mode     = spt_pkg::SPT_MODE_NORMAL;
            step_inc = spt_pkg::SPT_FULL_INC;
        end else begin
            mode     = spt_pkg::SPT_MODE_WAVE;
            step_inc = spt_pkg::SPT_FULL_INC;
        end
    end

    // Modulo-eight translator counter
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= spt_pkg::SPT_HOME_STATE;
        end else if (!pins_sync[spt_pkg::SPT_IX_RESET_N]) begin
            state <= spt_pkg::SPT_HOME_STATE;
        end else if (do_step) begin
            if (dir_ff) begin
                state <= state + step_inc;
            end else begin
                state <= state - step_inc;
            end
        end
    end

    // Internal chopper oscillator
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_cnt       <= spt_pkg::SPT_CNT_ZERO;
            int_osc_pulse <= 1'b0;
        end else if (osc_cnt == spt_pkg::SPT_CNT_ZERO) begin
            osc_cnt       <= OSC_RELOAD;
            int_osc_pulse <= 1'b1;
        end else begin
            osc_cnt       <= osc_cnt - spt_pkg::SPT_CNT_ONE;
            int_osc_pulse <= 1'b0;
        end
    end

    // External sync edge history
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_sync_prev <= 1'b0;
        end else begin
            ext_sync_prev <= pins_sync[spt_pkg::SPT_IX_EXTSYNC];
        end
    end

    // Slave devices take their chopper pulses from the shared sync line
    assign osc_pulse = pins_sync[spt_pkg::SPT_IX_OSC_GND] ?
                       (pins_sync[spt_pkg::SPT_IX_EXTSYNC] & ~ext_sync_prev) :
                       int_osc_pulse;

    // Sync pin repeats the internal oscillator only on the master,
    // and only once the grounded-oscillator pin has been synchronised
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_out <= 1'b0;
        end else begin
            sync_out <= int_osc_pulse & ~pins_sync[spt_pkg::SPT_IX_OSC_GND] & sync_fill[1];
        end
    end

    // Chopper latches: oscillator sets, comparator clears, set wins
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chopper_latch_ab <= 1'b1;
            chopper_latch_cd <= 1'b1;
        end else begin
            if (osc_pulse) begin
                chopper_latch_ab <= 1'b1;
            end else if (pins_sync[spt_pkg::SPT_IX_SENS_AB]) begin
                chopper_latch_ab <= 1'b0;
            end
            if (osc_pulse) begin
                chopper_latch_cd <= 1'b1;
            end else if (pins_sync[spt_pkg::SPT_IX_SENS_CD]) begin
                chopper_latch_cd <= 1'b0;
            end
        end
    end

    // Base phase pattern and its two pairs
    assign phase_pattern = spt_decode(state);
    assign pair_ab = phase_pattern[spt_pkg::SPT_AB_HI:spt_pkg::SPT_AB_LO];
    assign pair_cd = phase_pattern[spt_pkg::SPT_CD_HI:spt_pkg::SPT_CD_LO];

    // Drive computation: inhibits, chopping and enable gating
    always_comb begin
        next_phase  = phase_pattern;
        // Inhibit falls on an unpowered pair so its current decays fast
        next_inh_ab = (pair_ab != spt_pkg::SPT_PAIR_OFF);
        next_inh_cd = (pair_cd != spt_pkg::SPT_PAIR_OFF);
        if (mode == spt_pkg::SPT_MODE_NORMAL) begin
            next_inh_ab = 1'b1;
            next_inh_cd = 1'b1;
        end
        if (pins_sync[spt_pkg::SPT_IX_CTRL]) begin
            // Chop on phase lines: drive the idle line of an active pair
            if (!chopper_latch_ab && pair_ab != spt_pkg::SPT_PAIR_OFF) begin
                next_phase[spt_pkg::SPT_AB_HI:spt_pkg::SPT_AB_LO] = spt_pkg::SPT_PAIR_BOTH;
            end
            if (!chopper_latch_cd && pair_cd != spt_pkg::SPT_PAIR_OFF) begin
                next_phase[spt_pkg::SPT_CD_HI:spt_pkg::SPT_CD_LO] = spt_pkg::SPT_PAIR_BOTH;
            end
        end else begin
            // Chop on inhibit lines
            next_inh_ab = next_inh_ab & chopper_latch_ab;
            next_inh_cd = next_inh_cd & chopper_latch_cd;
        end
        if (!pins_sync[spt_pkg::SPT_IX_ENABLE]) begin
            next_phase  = 4'h0;
            next_inh_ab = 1'b0;
            next_inh_cd = 1'b0;
        end
    end

    // Registered power stage outputs
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_outputs_out     <= 4'h0;
            pair_ab_inhibit_n_out <= 1'b0;
            pair_cd_inhibit_n_out <= 1'b0;
        end else begin
            phase_outputs_out     <= next_phase;
            pair_ab_inhibit_n_out <= next_inh_ab;
            pair_cd_inhibit_n_out <= next_inh_cd;
        end
    end

    // Registered status outputs
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            home_out    <= 1'b0;
            dir_mem_out <= 1'b0;
        end else begin
            home_out    <= (phase_pattern == spt_pkg::SPT_PHASE_HOME);
            dir_mem_out <= ~dir_ff;
        end
    end

endmodule : spt_translator_chopper

/* testbench/spt_tc_sva.sv */
// Port-level assertions for the translator and chopper
`timescale 1ns/1ps
module spt_tc_sva #(
    parameter int unsigned OSC_PERIOD_CYC = 8,
    parameter int unsigned DBL_DELAY_CYC  = 10
) (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    // Pin inputs
    input wire logic       step_clk_n_in,
    input wire logic       rotation_dir_in,
    input wire logic       half_full_in,
    input wire logic       translator_reset_n_in,
    input wire logic       enable_in,
    input wire logic       chopper_target_in,
    input wire logic       current_sense_ab_in,
    input wire logic       current_sense_cd_in,
    input wire logic       ext_sync_in,
    input wire logic       chopper_osc_pin_grounded_in,
    input wire logic       doubler_grounded_in,
    // Design outputs
    input wire logic [3:0] phase_outputs_out,
    input wire logic       pair_ab_inhibit_n_out,
    input wire logic       pair_cd_inhibit_n_out,
    input wire logic       home_out,
    input wire logic       dir_mem_out,
    input wire logic       sync_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    int unsigned gap;
    logic        seen;

    // Cycles since the last oscillator pulse, trusted once a master pulse was seen
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gap  <= 0;
            seen <= 1'b0;
        end else if (chopper_osc_pin_grounded_in) begin
            seen <= 1'b0;
        end else if (sync_out) begin
            gap  <= 1;
            seen <= 1'b1;
        end else begin
            gap <= gap + 1;
        end
    end

    a_enable_low_quiet: assert property (!enable_in [*5] |->
        phase_outputs_out == 4'h0 && !pair_ab_inhibit_n_out && !pair_cd_inhibit_n_out)
        else $error("outputs active while enable low");
    a_reset_to_home: assert property (!translator_reset_n_in [*6] |-> home_out)
        else $error("translator not at home while held in reset");
    a_home_decode: assert property (enable_in [*5] ##0 (phase_outputs_out == 4'h5) |-> home_out)
        else $error("home not flagged at pattern 0101");
    a_normal_inhibit_high: assert property ((enable_in && chopper_target_in) [*6] ##0
        (phase_outputs_out inside {4'h5, 4'h9, 4'hA, 4'h6}) |-> pair_ab_inhibit_n_out && pair_cd_inhibit_n_out)
        else $error("inhibit low during two-phase drive");
    a_idle_pair_inhibit: assert property ((phase_outputs_out[3:2] != 2'h0 || !pair_ab_inhibit_n_out) &&
        (phase_outputs_out[1:0] != 2'h0 || !pair_cd_inhibit_n_out))
        else $error("inhibit high on a de-energised pair");
    a_step_advance: assert property ($rose(step_clk_n_in) && enable_in && translator_reset_n_in &&
        !current_sense_ab_in && !current_sense_cd_in |-> ##4 $changed(phase_outputs_out))
        else $error("phases did not move four cycles after a step edge");
    a_dir_memory: assert property ($stable(rotation_dir_in) [*6] |-> dir_mem_out != rotation_dir_in)
        else $error("direction memory not inverse of direction");
    a_osc_period: assert property (sync_out && seen && !chopper_osc_pin_grounded_in |->
        gap == OSC_PERIOD_CYC)
        else $error("oscillator pulse spacing wrong");
    a_sense_cuts_drive: assert property ((current_sense_ab_in && !chopper_target_in && enable_in) [*6]
        ##0 pair_ab_inhibit_n_out |=> !pair_ab_inhibit_n_out)
        else $error("drive not cut while sense at reference");
endmodule : spt_tc_sva

bind spt_translator_chopper spt_tc_sva #(.OSC_PERIOD_CYC(OSC_PERIOD_CYC), .DBL_DELAY_CYC(DBL_DELAY_CYC))
    i_spt_tc_sva (.*);

/* testbench/spt_ctrl_model.sv */
// Controller model that issues step strobes on request
`timescale 1ns/1ps
module spt_ctrl_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Bench request: one strobe, low for this count plus one cycle
    input  wire logic       go_in,
    input  wire logic [3:0] low_cyc_in,
    // Strobe to the translator and busy flag
    output logic            step_clk_n_out,
    output logic            busy_out
);
    logic [4:0] cnt;

    // Strobe low while count is above 8, then 8 settling cycles
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 5'h00;
        end else if (go_in && cnt == 5'h00) begin
            cnt <= {1'b0, low_cyc_in} + 5'h09;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end

    // Strobe idles high; the step lands on its release
    assign step_clk_n_out = !(cnt > 5'h08);
    assign busy_out       = cnt != 5'h00;
endmodule : spt_ctrl_model

/* testbench/tb_top.sv */
// Self-checking bench for the translator and chopper
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned OSC = 16;
    localparam int unsigned DBL = 10;
    logic       clk_in, arst_n_in, go, dir, half, trst_n, en, ctl;
    logic       sab, scd, esync, oscg, dblg, step_n, busy;
    logic       inh_ab, inh_cd, home, dmem, sync;
    logic [3:0] low, ph;
    logic [3:0] tbl [8];
    int         mismatches, checked, n, idx;

    spt_ctrl_model i_spt_ctrl_model (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go), .low_cyc_in(low),
        .step_clk_n_out(step_n), .busy_out(busy));
    spt_translator_chopper #(.OSC_PERIOD_CYC(OSC), .DBL_DELAY_CYC(DBL)) i_spt_translator_chopper (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .step_clk_n_in(step_n), .rotation_dir_in(dir),
        .half_full_in(half), .translator_reset_n_in(trst_n), .enable_in(en), .chopper_target_in(ctl),
        .current_sense_ab_in(sab), .current_sense_cd_in(scd), .ext_sync_in(esync),
        .chopper_osc_pin_grounded_in(oscg), .doubler_grounded_in(dblg), .phase_outputs_out(ph),
        .pair_ab_inhibit_n_out(inh_ab), .pair_cd_inhibit_n_out(inh_cd), .home_out(home),
        .dir_mem_out(dmem), .sync_out(sync));

    // Verdict and end of run
    task automatic complete_run;
        $display("counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Compare a design value
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Compare a cycle count
    task automatic chk_n(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n

    // Phases and inhibits; a pair is inhibited when both its lines are off
    task automatic chk_out(input logic [3:0] p);
        chk("phases", p, ph);
        chk("inhibits", {2'h0, |p[3:2], |p[1:0]}, {2'h0, inh_ab, inh_cd});
    endtask : chk_out

    task automatic idle(input int c);
        repeat (c) @(posedge clk_in);
    endtask : idle

    // One strobe through the controller model, bounded wait for it to settle
    task automatic step(input logic [3:0] l);
        @(posedge clk_in);
        go  <= 1'b1;
        low <= l;
        @(posedge clk_in);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (n >= 40) begin
            mismatches++;
            complete_run();
        end
    endtask : step

    // Count cycles over two oscillator periods: inhibit AB open, or phases chopped to 1101
    task automatic win(input bit phases);
        n = 0;
        repeat (2 * OSC) begin
            @(posedge clk_in);
            n += phases ? int'(ph === 4'hD) : int'(inh_ab === 1'b1);
        end
    endtask : win

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial begin
        tbl = '{4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4};
        {arst_n_in, go, trst_n, sab, scd, esync, oscg} = 7'h00;
        {dir, half, en, ctl, dblg} = 5'h1F;
        low = 4'h1;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        idle(4);
        trst_n <= 1'b1;
        idle(6);
        chk_out(4'h5);
        chk("home", 4'h1, {3'h0, home});
        $display("test reset done");
        for (idx = 1; idx <= 8; idx++) begin
            step(idx[3:0]);
            chk_out(tbl[idx % 8]);
        end
        chk("dir memory", 4'h0, {3'h0, dmem});
        dir <= 1'b0;
        idle(4);
        for (idx = 1; idx <= 8; idx++) begin
            step(4'h2);
            chk_out(tbl[(8 - idx) % 8]);
        end
        chk("dir memory", 4'h1, {3'h0, dmem});
        dir <= 1'b1;
        half <= 1'b0;
        $display("test half step both ways done");
        for (idx = 1; idx <= 4; idx++) begin
            step(4'h1);
            chk_out(tbl[(2 * idx) % 8]);
        end
        half <= 1'b1;
        step(4'h1);
        half <= 1'b0;
        idle(4);
        for (idx = 1; idx <= 4; idx++) begin
            step(4'h3);
            chk_out(tbl[(2 * idx + 1) % 8]);
        end
        trst_n <= 1'b0;
        idle(4);
        step(4'h1);
        chk_out(4'h5);
        trst_n <= 1'b1;
        half   <= 1'b1;
        en     <= 1'b0;
        idle(6);
        chk_out(4'h0);
        chk("home", 4'h1, {3'h0, home});
        en  <= 1'b1;
        ctl <= 1'b0;
        sab <= 1'b1;
        $display("test full step, reset and enable done");
        idle(8);
        win(1'b0);
        chk_n("open inhibit cycles", 2, n);
        chk("cd inhibit", 4'h1, {3'h0, inh_cd});
        ctl <= 1'b1;
        idle(8);
        win(1'b1);
        chk_n("chopped phase cycles", 2 * OSC - 2, n);
        chk("inhibits", 4'h3, {2'h0, inh_ab, inh_cd});
        sab <= 1'b0;
        idle(2 * OSC);
        chk_out(4'h5);
        oscg <= 1'b1;
        ctl  <= 1'b0;
        sab  <= 1'b1;
        scd  <= 1'b1;
        idle(6);
        sab <= 1'b0;
        scd <= 1'b0;
        idle(2 * OSC);
        chk("ab inhibit", 4'h0, {3'h0, inh_ab});
        chk("cd inhibit", 4'h0, {3'h0, inh_cd});
        chk("sync", 4'h0, {3'h0, sync});
        esync <= 1'b1;
        idle(6);
        chk("ab inhibit", 4'h1, {3'h0, inh_ab});
        chk("cd inhibit", 4'h1, {3'h0, inh_cd});
        {esync, oscg, ctl, dblg} <= 4'h2;
        $display("test chopper done");
        idle(4);
        step(4'h1);
        chk_out(tbl[1]);
        // Ghost output lands DBL cycles after the real one: still old one cycle before, new at that cycle
        idle(DBL - 5);
        chk_out(tbl[1]);
        idle(1);
        chk_out(tbl[2]);
        dblg <= 1'b1;
        idle(4);
        step(4'h1);
        idle(16);
        chk_out(tbl[3]);
        $display("test doubler done");
        complete_run();
    end
endmodule : tb_top
